// ==== include/indicator_pkg.sv ====
// Constants and select codes for the status indicator controller
// Contract
// R1: First select field is bits 15:12; code 0000 (reset) shows link speed continuously.
// R2: Codes 0001, 0010, 0011 show transmit, receive, collision events, stretched.
// R3: Code 0100 shows link status, 0101 duplex status, continuously, unstretched.
// R4: Code 0111 shows receive or transmit activity, stretched.
// R5: Test codes: 1000 on, 1001 off, 1010 fast blink, 1011 slow blink.
// R6: Code 1100 shows link and receive combined, always stretched.
// R7: Code 1101 shows duplex and collision combined, always stretched.
// R8: Link/receive display is solid on with link; receive events make it blink (the code also blinks it on transmit events, via the activity slot).
// R9: Receive activity blinks the link/receive display even with link down.
// R10: Duplex/collision display is solid on in full duplex; collisions make it blink.
// R11: Combined displays stay stretched whatever the global stretch enable says.
// R12: Second select field is bits 11:8, same codes, reset 0100 (link).
// R13: Third select field is bits 7:4, same codes, reset 0010 (receive).
// R14: Bits 3:2 pick stretch 30 ms (00, reset), 60 ms (01), 100 ms (10).
// R15: Bit 1 enables stretching of all indicators when set; resets to one.
// R16: Codes 0110 and 1111 hold the indicator off; stretch counts come from core clock.
package indicator_pkg;

  // Management register port
  localparam int REG_ADDR_W = 5;
  localparam logic [4:0] CFG_ADDR = 5'h14;
  localparam logic [15:0] CFG_RESET = 16'h0422;
  localparam logic [15:0] CFG_WRITE_MASK = 16'hfffe;

  // Values after reset of the indicator, read data and blink registers
  localparam logic [2:0] LED_RESET = 3'h0;
  localparam logic [15:0] RDATA_RESET = 16'h0000;
  localparam int BLINK_RESET = 0;

  // Field positions inside the configuration register
  localparam int SEL1_LSB = 12;
  localparam int SEL2_LSB = 8;
  localparam int SEL3_LSB = 4;
  localparam int STRETCH_TIME_LSB = 2;
  localparam int STRETCH_EN_BIT = 1;
  localparam int SEL_W = 4;

  // Indicator source codes
  typedef enum logic [3:0] {
    SEL_SPEED    = 4'h0,
    SEL_TX       = 4'h1,
    SEL_RX       = 4'h2,
    SEL_COL      = 4'h3,
    SEL_LINK     = 4'h4,
    SEL_DUPLEX   = 4'h5,
    SEL_UNUSED_A = 4'h6,
    SEL_ACTIVITY = 4'h7,
    SEL_TEST_ON  = 4'h8,
    SEL_TEST_OFF = 4'h9,
    SEL_FAST     = 4'ha,
    SEL_SLOW     = 4'hb,
    SEL_LINK_RX  = 4'hc,
    SEL_DUP_COL  = 4'hd,
    SEL_UNUSED_B = 4'he,
    SEL_UNUSED_C = 4'hf
  } sel_t;

  // Stretch time codes
  localparam logic [1:0] STRETCH_CODE_30 = 2'h0;
  localparam logic [1:0] STRETCH_CODE_60 = 2'h1;
  localparam logic [1:0] STRETCH_CODE_100 = 2'h2;

  // Timing, in milliseconds and in core clock cycles
  localparam int CLK_HZ = 100000000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int STRETCH_30_MS = 30;
  localparam int STRETCH_60_MS = 60;
  localparam int STRETCH_100_MS = 100;
  localparam int STRETCH_30_CYC = STRETCH_30_MS * CYC_PER_MS;
  localparam int STRETCH_60_CYC = STRETCH_60_MS * CYC_PER_MS;
  localparam int STRETCH_100_CYC = STRETCH_100_MS * CYC_PER_MS;

  // Blink divider taps on a free-running counter
  localparam int BLINK_W = 26;
  localparam int FAST_BLINK_BIT = 22;
  localparam int SLOW_BLINK_BIT = 24;
  localparam int STRETCH_CNT_W = 24;

endpackage

// ==== hdl/event_stretcher.sv ====
// Retriggerable pulse stretcher for one event source
`timescale 1ns/100ps
`default_nettype none
module event_stretcher #(
  parameter int CNT_W = 24
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // Event and length
  input wire logic i_event,
  input wire logic [CNT_W-1:0] i_load_cycles,
  // Stretched level
  output logic o_active
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic active;
  } str_state_t;

  str_state_t st_r;
  str_state_t st_nxt;

  // Each new event restarts the full stretch, so a busy line stays lit
  always_comb begin
    st_nxt = st_r;
    if (i_event) begin
      st_nxt.cnt = i_load_cycles;
    end else if (st_r.cnt != '0) begin
      st_nxt.cnt = st_r.cnt - CNT_W'(1);
    end
    st_nxt.active = (st_nxt.cnt != '0);
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_active = st_r.active;

endmodule
`default_nettype wire

// ==== hdl/indicator_led_control.sv ====
// Three programmable status indicators with event stretching
`timescale 1ns/100ps
`default_nettype none
module indicator_led_control
  import indicator_pkg::*;
#(
  parameter int STRETCH_SHORT_CYC = indicator_pkg::STRETCH_30_CYC,
  parameter int STRETCH_MID_CYC = indicator_pkg::STRETCH_60_CYC,
  parameter int STRETCH_LONG_CYC = indicator_pkg::STRETCH_100_CYC,
  parameter int CNT_W = indicator_pkg::STRETCH_CNT_W,
  parameter int FAST_BIT = indicator_pkg::FAST_BLINK_BIT,
  parameter int SLOW_BIT = indicator_pkg::SLOW_BLINK_BIT
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // Management register port
  input wire logic [indicator_pkg::REG_ADDR_W-1:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [15:0] i_reg_wdata,
  output logic [15:0] o_reg_rdata,
  // Transceiver status levels
  input wire logic i_speed_100,
  input wire logic i_link_up,
  input wire logic i_full_duplex,
  // Transceiver event pulses
  input wire logic i_tx_event,
  input wire logic i_rx_event,
  input wire logic i_col_event,
  // Indicator drive, high lights the indicator
  output logic [2:0] o_led
);
  import indicator_pkg::*;

  // Stretcher slots; activity has its own so tx and rx bursts merge into one display
  localparam int NUM_EV = 4;
  localparam int EV_TX = 0;
  localparam int EV_RX = 1;
  localparam int EV_COL = 2;
  localparam int EV_ACT = 3;

  // All controller state but the stretch counters in one word, so reset and update stay in step
  typedef struct packed {
    logic [15:0] cfg;
    logic [2:0] led;
    logic [15:0] rdata;
    logic [BLINK_W-1:0] blink;
  } ctl_state_t;

  // State after reset: documented field defaults, dark indicators, blink phase zero
  localparam ctl_state_t CTL_RESET = '{
    cfg: CFG_RESET,
    led: LED_RESET,
    rdata: RDATA_RESET,
    blink: BLINK_W'(BLINK_RESET)
  };

  ctl_state_t st_r;
  ctl_state_t st_nxt;

  // Raw and stretched event vectors, indexed by the slots above
  logic [NUM_EV-1:0] ev_raw;
  logic [NUM_EV-1:0] ev_str;
  logic [CNT_W-1:0] load_cycles;
  logic stretch_en;

  // Stretch length from the time field; the reserved code falls back to the longest
  function automatic logic [CNT_W-1:0] stretch_len(input logic [1:0] code);
    logic [CNT_W-1:0] len;
    len = CNT_W'(STRETCH_LONG_CYC);
    unique case (code)
      STRETCH_CODE_30: len = CNT_W'(STRETCH_SHORT_CYC);
      STRETCH_CODE_60: len = CNT_W'(STRETCH_MID_CYC);
      STRETCH_CODE_100: len = CNT_W'(STRETCH_LONG_CYC);
      default: len = CNT_W'(STRETCH_LONG_CYC);
    endcase
    return len;
  endfunction

  // Address decode shared by the write and read paths
  function automatic logic cfg_hit(input logic [REG_ADDR_W-1:0] addr);
    return (addr == CFG_ADDR);
  endfunction

  // One four-bit select field out of the configuration word
  function automatic logic [SEL_W-1:0] sel_field(input logic [15:0] cfg, input int lsb);
    // The start is always one of the package field positions
    return cfg[lsb +: SEL_W];
  endfunction

  // Next configuration word for one cycle of the register port
  function automatic logic [15:0] next_cfg(
    input logic [15:0] cur,
    input logic wr,
    input logic [REG_ADDR_W-1:0] addr,
    input logic [15:0] wdata
  );
    logic [15:0] nxt;
    nxt = cur;
    // Reserved bit 0 is masked off, so it always reads back as zero
    if (wr && cfg_hit(addr)) begin
      nxt = wdata & CFG_WRITE_MASK;
    end
    return nxt;
  endfunction

  // Read data holds between strobes, so a slow master may take it late
  function automatic logic [15:0] next_rdata(
    input logic [15:0] cur,
    input logic rd,
    input logic [REG_ADDR_W-1:0] addr,
    input logic [15:0] cfg
  );
    logic [15:0] nxt;
    nxt = cur;
    // Unmapped addresses read as zero
    if (rd) begin
      nxt = cfg_hit(addr) ? cfg : 16'h0000;
    end
    return nxt;
  endfunction

  // Shown level for one indicator, used for all three select fields
  function automatic logic led_level(
    input logic [SEL_W-1:0] code,
    input logic str_en,
    input logic [NUM_EV-1:0] raw,
    input logic [NUM_EV-1:0] str,
    input logic fast,
    input logic slow,
    input logic speed,
    input logic link,
    input logic dup
  );
    logic lvl;
    logic [NUM_EV-1:0] ev;
    lvl = 1'b0;
    // Single-event displays follow the raw pulse when stretching is off
    ev = str_en ? str : raw; // see R15
    unique case (sel_t'(code))
      SEL_SPEED: lvl = speed; // see R1
      SEL_TX: lvl = ev[EV_TX]; // see R2
      SEL_RX: lvl = ev[EV_RX]; // see R2
      SEL_COL: lvl = ev[EV_COL]; // see R2
      SEL_LINK: lvl = link; // see R3
      SEL_DUPLEX: lvl = dup; // see R3
      SEL_ACTIVITY: lvl = ev[EV_ACT]; // see R4
      SEL_TEST_ON: lvl = 1'b1; // see R5
      SEL_TEST_OFF: lvl = 1'b0; // see R5
      SEL_FAST: lvl = fast; // see R5
      SEL_SLOW: lvl = slow; // see R5
      // Combined displays read the stretched events unconditionally
      SEL_LINK_RX: lvl = str[EV_ACT] ? fast : link; // see R6, R8, R9, R11
      SEL_DUP_COL: lvl = str[EV_COL] ? fast : dup; // see R7, R10, R11
      // Unused codes stay dark rather than show a stray source
      SEL_UNUSED_A, SEL_UNUSED_B, SEL_UNUSED_C: lvl = 1'b0; // see R16
    endcase
    return lvl;
  endfunction

  // Event sources; activity merges both data directions
  assign ev_raw[EV_TX] = i_tx_event;
  assign ev_raw[EV_RX] = i_rx_event;
  assign ev_raw[EV_COL] = i_col_event;
  assign ev_raw[EV_ACT] = i_tx_event | i_rx_event; // see R4

  // A changed length applies from the next event; a running stretch keeps its count
  assign stretch_en = st_r.cfg[STRETCH_EN_BIT]; // see R15
  assign load_cycles = stretch_len(st_r.cfg[STRETCH_TIME_LSB +: 2]); // see R14

  // One stretcher per source, counted on the core clock
  for (genvar g = 0; g < NUM_EV; g++) begin : g_str
    event_stretcher #(
      .CNT_W(CNT_W)
    ) u_event_stretcher (
      .i_core_clk(i_core_clk),
      .i_srst(i_srst),
      .i_event(ev_raw[g]),
      .i_load_cycles(load_cycles), // see R16
      .o_active(ev_str[g])
    );
  end

  // Register access, blink divider and indicator decode
  always_comb begin
    logic [SEL_W-1:0] sel1;
    logic [SEL_W-1:0] sel2;
    logic [SEL_W-1:0] sel3;
    logic fast;
    logic slow;
    // Select fields and blink phases for this cycle
    sel1 = sel_field(st_r.cfg, SEL1_LSB); // see R1
    sel2 = sel_field(st_r.cfg, SEL2_LSB); // see R12
    sel3 = sel_field(st_r.cfg, SEL3_LSB); // see R13
    fast = st_r.blink[FAST_BIT];
    slow = st_r.blink[SLOW_BIT];
    st_nxt = st_r;
    // One free-running divider feeds every blink, so all indicators blink in phase
    st_nxt.blink = st_r.blink + BLINK_W'(1);
    // A read in the same cycle as a write returns the word held before the write
    st_nxt.cfg = next_cfg(st_r.cfg, i_reg_wr, i_reg_addr, i_reg_wdata);
    st_nxt.rdata = next_rdata(st_r.rdata, i_reg_rd, i_reg_addr, st_r.cfg);
    // Each indicator decodes its own field; registering the result keeps the drive glitch free
    st_nxt.led[0] = led_level(sel1, stretch_en, ev_raw, ev_str, fast, slow,
                              i_speed_100, i_link_up, i_full_duplex);
    st_nxt.led[1] = led_level(sel2, stretch_en, ev_raw, ev_str, fast, slow,
                              i_speed_100, i_link_up, i_full_duplex);
    st_nxt.led[2] = led_level(sel3, stretch_en, ev_raw, ev_str, fast, slow,
                              i_speed_100, i_link_up, i_full_duplex);
  end

  // Reset loads the documented field defaults
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      st_r <= CTL_RESET; // see R1, R12, R13, R14, R15
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from the state registers
  assign o_led = st_r.led;
  assign o_reg_rdata = st_r.rdata;

endmodule
`default_nettype wire

// ==== verif/indicator_led_control_asserts.sv ====
// Port checker for the indicator controller
`timescale 1ns/100ps
`default_nettype none
module indicator_led_control_asserts #(
  parameter int STRETCH_SHORT_CYC = 20,
  parameter int STRETCH_MID_CYC = 40,
  parameter int STRETCH_LONG_CYC = 60
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // Register port and status
  input wire logic [4:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [15:0] i_reg_wdata,
  input wire logic i_speed_100,
  input wire logic i_link_up,
  input wire logic i_rx_event,
  // Outputs
  input wire logic [15:0] o_reg_rdata,
  input wire logic [2:0] o_led
);
  logic [15:0] cfg_r;
  logic [7:0] quiet_r;
  int lim;
  default clocking dcb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  // Shadow config and cycles since the last receive event
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      cfg_r <= 16'h0422;
      quiet_r <= 8'hff;
    end else begin
      cfg_r <= (i_reg_wr && i_reg_addr == 5'h14) ? (i_reg_wdata & 16'hfffe) : cfg_r;
      quiet_r <= i_rx_event ? 8'h00 : quiet_r + {7'h00, quiet_r != 8'hff};
    end
  end
  // Reserved time code runs the long length
  assign lim = (cfg_r[3:2] == 2'h0) ? STRETCH_SHORT_CYC : (cfg_r[3:2] == 2'h1) ? STRETCH_MID_CYC : STRETCH_LONG_CYC;
  property p_rd; i_reg_rd && i_reg_addr == 5'h14 |=> o_reg_rdata == $past(cfg_r); endproperty
  a_rd: assert property (p_rd) else $error("readback");
  property p_spd; !i_srst && cfg_r[15:12] == 4'h0 |=> o_led[0] == $past(i_speed_100); endproperty
  a_spd: assert property (p_spd) else $error("speed");
  property p_lnk; !i_srst && cfg_r[11:8] == 4'h4 |=> o_led[1] == $past(i_link_up); endproperty
  a_lnk: assert property (p_lnk) else $error("link");
  property p_on; !i_srst && cfg_r[15:12] == 4'h8 |=> o_led[0]; endproperty
  a_on: assert property (p_on) else $error("forced on");
  property p_off; !i_srst && cfg_r[15:12] inside {4'h6, 4'h9, 4'he, 4'hf} |=> !o_led[0]; endproperty
  a_off: assert property (p_off) else $error("forced off");
  property p_str; !i_srst && cfg_r[7:4] == 4'h2 && cfg_r[1] && i_rx_event |-> ##2 o_led[2] [*8]; endproperty
  a_str: assert property (p_str) else $error("stretch");
  property p_raw; !i_srst && cfg_r[7:4] == 4'h2 && !cfg_r[1] |=> o_led[2] == $past(i_rx_event); endproperty
  a_raw: assert property (p_raw) else $error("raw");
  property p_len; !i_srst && cfg_r[7:4] == 4'h2 && quiet_r > lim + 3 |-> !o_led[2]; endproperty
  a_len: assert property (p_len) else $error("length");
  c_str: cover property (cfg_r[7:4] == 4'h2 && cfg_r[1] && i_rx_event);
  c_cmb: cover property (cfg_r[15:12] == 4'hc && i_rx_event);
  c_wr: cover property (i_reg_wr && i_reg_addr == 5'h14);
endmodule
`default_nettype wire

// ==== verif/led_board.sv ====
// Board model of three indicators, counting lit cycles and changes
`timescale 1ns/100ps
`default_nettype none
module led_board (
  // Clock and window control
  input wire logic i_core_clk,
  input wire logic i_clear,
  // Indicator drive
  input wire logic [2:0] i_led,
  // Counts per indicator
  output logic [2:0][7:0] o_on_cnt,
  output logic [2:0][7:0] o_tog_cnt
);
  logic [2:0] prev_r;
  // A lamp has no state; counts are only for the bench
  always_ff @(posedge i_core_clk) begin
    prev_r <= i_led;
    for (int k = 0; k < 3; k++) begin
      o_on_cnt[k] <= i_clear ? 8'h00 : o_on_cnt[k] + {7'h00, i_led[k]};
      o_tog_cnt[k] <= i_clear ? 8'h00 : o_tog_cnt[k] + {7'h00, i_led[k] ^ prev_r[k]};
    end
  end
endmodule
`default_nettype wire

// ==== verif/indicator_led_control_test.sv ====
// Self-checking bench for the indicator controller
`timescale 1ns/100ps
`default_nettype none
module indicator_led_control_test;
  import indicator_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [4:0] i_reg_addr = 5'h00;
  logic [15:0] i_reg_wdata = 16'h0000;
  logic [15:0] o_reg_rdata;
  logic [2:0] o_led;
  logic i_speed_100 = 1'b0;
  logic i_link_up = 1'b0;
  logic i_full_duplex = 1'b0;
  logic i_tx_event = 1'b0;
  logic i_rx_event = 1'b0;
  logic i_col_event = 1'b0;
  logic clr = 1'b1;
  logic [2:0][7:0] on_cnt;
  logic [2:0][7:0] tog_cnt;
  logic [5:0] s;
  logic [15:0] r;
  logic [7:0] combo [5] = '{8'hc8, 8'hca, 8'hc2, 8'hd4, 8'hd5};
  int len [4] = '{20, 40, 60, 60};
  int miscompares = 0;
  int samples_checked = 0;
  indicator_led_control #(.STRETCH_SHORT_CYC(20), .STRETCH_MID_CYC(40), .STRETCH_LONG_CYC(60), .FAST_BIT(2),
    .SLOW_BIT(4)) u_indicator_led_control (.i_core_clk, .i_srst, .i_reg_addr, .i_reg_wr, .i_reg_rd,
    .i_reg_wdata, .o_reg_rdata, .i_speed_100, .i_link_up, .i_full_duplex, .i_tx_event, .i_rx_event,
    .i_col_event, .o_led);
  led_board u_led_board (.i_core_clk, .i_clear(clr), .i_led(o_led), .o_on_cnt(on_cnt), .o_tog_cnt(tog_cnt));
  // 100 MHz core clock
  always #5 i_core_clk = ~i_core_clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Counts carry a cycle of phase slack, so accept a range
  task automatic rng(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
    chk({8'h00, (got >= lo && got <= hi) ? lo : got}, {8'h00, lo});
  endtask
  // Optional write, then a read of the same address on the next edge
  task automatic acc(input logic [4:0] a, input logic [15:0] v, input logic w, input logic [15:0] exp);
    @(posedge i_core_clk);
    i_reg_wr <= w;
    i_reg_addr <= a;
    i_reg_wdata <= v;
    @(posedge i_core_clk);
    i_reg_wr <= 1'b0;
    i_reg_rd <= 1'b1;
    @(posedge i_core_clk);
    i_reg_rd <= 1'b0;
    #1 chk(o_reg_rdata, exp);
  endtask
  // Drain old stretch, clear the board, send one pulse, watch w cycles
  task automatic pulse(input logic rx, input logic col, input int w);
    @(posedge i_core_clk);
    {i_col_event, i_rx_event, i_tx_event} <= 3'h0;
    repeat (70) @(posedge i_core_clk);
    clr <= 1'b1;
    @(posedge i_core_clk);
    clr <= 1'b0;
    {i_col_event, i_rx_event} <= {col, rx};
    @(posedge i_core_clk);
    {i_col_event, i_rx_event} <= 2'h0;
    repeat (w) @(posedge i_core_clk);
    #1;
  endtask
  // Source of one indicator with stretching off; s is col,rx,tx,dup,link,speed
  function automatic logic exp_led(input logic [3:0] c, input logic [5:0] v);
    case (c)
      4'h0: return v[0];
      4'h1: return v[3];
      4'h2: return v[4];
      4'h3: return v[5];
      4'h4: return v[1];
      4'h5: return v[2];
      4'h7: return v[3] | v[4];
      4'h8: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
  task automatic results;
    $display("miscompares %0d samples_checked %0d", miscompares, samples_checked);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(32'hfaff));
    repeat (2) @(posedge i_core_clk);
    i_srst <= 1'b0;
    acc(5'h14, 16'h0000, 1'b0, 16'h0422);
    acc(5'h13, 16'hffff, 1'b1, 16'h0000);
    r = 16'($urandom);
    acc(5'h14, r, 1'b1, r & 16'hfffe);
    // Every non-blinking code on the first indicator, random sources
    for (int c = 0; c < 16; c++) begin
      if (c >= 10 && c <= 13) continue;
      acc(5'h14, {c[3:0], 12'h420}, 1'b1, {c[3:0], 12'h420});
      repeat (8) begin
        s = 6'($urandom);
        @(posedge i_core_clk);
        {i_col_event, i_rx_event, i_tx_event, i_full_duplex, i_link_up, i_speed_100} <= s;
        @(posedge i_core_clk);
        #1 chk({13'h0, o_led}, {13'h0, s[4], s[1], exp_led(c[3:0], s)});
      end
    end
    // One receive and collision pulse per stretch length, reserved code included
    for (int t = 0; t < 4; t++) begin
      acc(5'h14, {12'h342, t[1:0], 2'h2}, 1'b1, {12'h342, t[1:0], 2'h2});
      pulse(1'b1, 1'b1, 100);
      rng(on_cnt[2], 8'(len[t] - 1), 8'(len[t] + 1));
      rng(on_cnt[0], 8'(len[t] - 1), 8'(len[t] + 1));
    end
    acc(5'h14, 16'ha722, 1'b1, 16'ha722);
    pulse(1'b1, 1'b0, 60);
    rng(tog_cnt[0], 8'h0e, 8'h11);
    rng(on_cnt[1], 8'(len[0] - 1), 8'(len[0] + 1));
    acc(5'h14, 16'hb420, 1'b1, 16'hb420);
    pulse(1'b0, 1'b0, 60);
    rng(tog_cnt[0], 8'h03, 8'h05);
    // Combined displays with global stretching off
    foreach (combo[k]) begin
      acc(5'h14, {combo[k][7:4], 12'h420}, 1'b1, {combo[k][7:4], 12'h420});
      @(posedge i_core_clk);
      {i_link_up, i_full_duplex} <= combo[k][3:2];
      pulse(combo[k][1], combo[k][0], 40);
      if (combo[k][1:0] != 2'h0) rng(tog_cnt[0], 8'h04, 8'h0c);
      else rng(on_cnt[0], 8'h28, 8'h2c);
    end
    results();
  end
endmodule
bind indicator_led_control indicator_led_control_asserts #(.STRETCH_SHORT_CYC(STRETCH_SHORT_CYC),
  .STRETCH_MID_CYC(STRETCH_MID_CYC), .STRETCH_LONG_CYC(STRETCH_LONG_CYC)) u_asserts (.i_core_clk, .i_srst,
  .i_reg_addr, .i_reg_wr, .i_reg_rd, .i_reg_wdata, .i_speed_100, .i_link_up, .i_rx_event, .o_reg_rdata, .o_led);
`default_nettype wire
